// file: port_alternate_function_mux.sv
// alternate-function mux for pins 02-06, 10 and 30-35
// assumes pad inputs are synchronous to clock and control bits are held by software
//
// What this block does and what software must do
// [R1] pin 02 alternate mode feeds the nmi input
// [R2] pin 03 selects irq0, adc trigger, one-hertz
// [R3] pin 04 selects irq1, rtc divided, rtc clock
// [R4] pin 05 irq2; debug mode forces debug reset
// [R5] pin 06 alternate mode feeds irq3 only
// [R6] pin 10 direction bit selects dac output
// [R7] pin 30 drives uart tx or serial data
// [R8] pin 31 feeds uart rx+irq7, or serial data
// [R9] pin 32 uart clock, serial clock, timer p0
// [R10] pins 33-35 timer inputs or timer outputs
// [R11] alternate function sets direction, not port bits
// [R12] software disables irq7 edges while receiving uart
// [R13] software stops uart reception when using irq7
// [R14] expansion bits only where the variant has them
// [R15] mode and function bits only on ports 0,3
// [R16] port 1 direction absent on smallest variant
// [R17] mode bit 0 gives plain general purpose port
// [R18] reserved codes connect no peripheral output
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_mux #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      resetn,
  // software control bits
  input  wire port_mux_pkg::pin_ctrl_t   ctrl,
  input  wire logic                      onchip_debug_mode_bit,
  input  wire logic                      irq7_rising_edge_enable,
  input  wire logic                      irq7_falling_edge_enable,
  input  wire logic                      uart_rx_enable_bit,
  // peripheral side
  input  wire port_mux_pkg::periph_out_t from_periph,
  output port_mux_pkg::periph_in_t       to_periph_r,
  output logic                           dac_pin_select_r,
  // pad side
  input  wire logic [11:0]               pin_in,
  output logic [11:0]                    pin_out,
  output logic [11:0]                    pin_oe,
  // status
  output logic [11:0]                    pin_level_r,
  output logic                           shared_pin_conflict_r
);
  import port_mux_pkg::*;

  // ------------------------------------------------------------
  // effective controls
  // ------------------------------------------------------------
  pin_ctrl_t eff;

  port_reg_presence #(
    .SMALL_VARIANT (SMALL_VARIANT)
  ) u_presence (
    .raw (ctrl),
    .eff (eff)
  );

  logic [NUM_PINS-1:0] alt;
  logic [NUM_PINS-1:0] fsel;
  logic [1:0]          sel03;
  logic [1:0]          sel04;
  logic [1:0]          sel32;
  logic                dbg;

  assign alt   = eff.port_alt_enable_reg;
  assign fsel  = eff.port_func_select_reg;
  assign sel03 = {eff.port_func_select_ext_reg[PIN_03], fsel[PIN_03]};
  assign sel04 = {eff.port_func_select_ext_reg[PIN_04], fsel[PIN_04]};
  assign sel32 = {eff.port_func_select_ext_reg[PIN_32], fsel[PIN_32]};
  assign dbg   = (onchip_debug_mode_bit == DEBUG_ON);

  // ------------------------------------------------------------
  // pad sampling
  // ------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_s;

  assign pin_s = pin_level_r;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_level_r <= PIN_RESET;
    end else begin
      pin_level_r <= pin_in;
    end
  end

  // ------------------------------------------------------------
  // pad to peripheral decode
  // ------------------------------------------------------------
  logic       m03_irq0;
  logic       m03_adc;
  logic       m03_1hz;
  logic       m04_irq1;
  logic       m31_rx;
  logic       m31_sdi;
  logic       m32_uclk;
  logic       m32_sclk;
  logic       m32_cap;
  logic       m33_in;
  logic       m34_in;
  logic       m35_in;
  periph_in_t to_periph_nxt;

  assign m03_irq0 = alt[PIN_03] && (sel03 == P03_IRQ0); // [R2]
  assign m03_adc  = alt[PIN_03] && (sel03 == P03_ADC); // [R2]
  assign m03_1hz  = alt[PIN_03] && (sel03 == P03_RTC_ONE_HERTZ); // [R2]
  assign m04_irq1 = alt[PIN_04] && (sel04 == P04_IRQ1); // [R3]
  assign m31_rx   = alt[PIN_31] && (fsel[PIN_31] == FUNC_0); // [R8]
  assign m31_sdi  = alt[PIN_31] && (fsel[PIN_31] == FUNC_1); // [R8]
  assign m32_uclk = alt[PIN_32] && (sel32 == P32_UCLK); // [R9]
  assign m32_sclk = alt[PIN_32] && (sel32 == P32_SCLK); // [R9]
  assign m32_cap  = alt[PIN_32] && (sel32 == P32_CAP); // [R9]
  assign m33_in   = alt[PIN_33] && (fsel[PIN_33] == FUNC_0); // [R10]
  assign m34_in   = alt[PIN_34] && (fsel[PIN_34] == FUNC_0); // [R10]
  assign m35_in   = alt[PIN_35] && (fsel[PIN_35] == FUNC_0); // [R10]

  // deselected inputs sit at their idle level so peripherals see no edges
  assign to_periph_nxt = '{
    nmi_in:             alt[PIN_02] & pin_s[PIN_02], // [R1]
    ext_irq_in_0:       m03_irq0 & pin_s[PIN_03],
    ext_irq_in_1:       m04_irq1 & pin_s[PIN_04],
    ext_irq_in_2:       alt[PIN_05] & ~dbg & pin_s[PIN_05], // [R4]
    ext_irq_in_3:       alt[PIN_06] & pin_s[PIN_06], // [R5]
    ext_irq_in_7:       m31_rx & pin_s[PIN_31], // [R8]
    adc_ext_trigger_in: m03_adc & pin_s[PIN_03],
    rtc_one_hertz:      m03_1hz & pin_s[PIN_03],
    debug_reset_in:     dbg & pin_s[PIN_05], // [R4]
    uart_rx_in:         m31_rx ? pin_s[PIN_31] : RX_IDLE, // [R8]
    uart_clk_in:        m32_uclk & pin_s[PIN_32],
    serial_data_in:     m31_sdi & pin_s[PIN_31],
    serial_clk_in:      m32_sclk & pin_s[PIN_32],
    timer_p0_cap_in_0:  m32_cap & pin_s[PIN_32],
    timer_p0_cap_in_1:  m33_in & pin_s[PIN_33],
    timer_p1_cap_in_0:  m34_in & pin_s[PIN_34],
    timer_p1_cap_in_1:  m35_in & pin_s[PIN_35]
  };

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      to_periph_r <= PERIPH_IN_RESET;
    end else begin
      to_periph_r <= to_periph_nxt;
    end
  end

  // ------------------------------------------------------------
  // peripheral to pad drivers
  // ------------------------------------------------------------
  logic oe04;
  logic val04;
  logic val30;
  logic oe32;
  logic val32;
  logic oe33;
  logic oe34;
  logic oe35;
  logic [NUM_PINS-1:0] alt_oe;
  logic [NUM_PINS-1:0] alt_val;
  logic [NUM_PINS-1:0] cell_alt;
  logic [NUM_PINS-1:0] cell_dir;

  // reserved code 11 on pin 04 leaves the pad undriven
  assign oe04  = alt[PIN_04] && ((sel04 == P04_RTC_DIVIDED_CLK_OUT) || (sel04 == P04_RTC_CLK_OUT)); // [R3] [R18]
  assign val04 = (sel04 == P04_RTC_DIVIDED_CLK_OUT) ? from_periph.rtc_divided_clk_out
                                       : from_periph.rtc_clk_out; // [R3]
  assign val30 = (fsel[PIN_30] == FUNC_1) ? from_periph.serial_data_out
                                          : from_periph.uart_tx_out; // [R7]
  // serial clock direction follows the serial unit, not the port bits
  assign oe32  = ((sel32 == P32_SCLK) && from_periph.serial_clk_oe)
                 || (sel32 == P32_TOUT); // [R9] [R11]
  assign val32 = (sel32 == P32_TOUT) ? from_periph.timer_p0_out_0
                                     : from_periph.serial_clk_out; // [R9]
  assign oe33  = (fsel[PIN_33] == FUNC_1); // [R10]
  assign oe34  = (fsel[PIN_34] == FUNC_1); // [R10]
  assign oe35  = (fsel[PIN_35] == FUNC_1); // [R10]

  assign alt_oe = {oe35, oe34, oe33, oe32, 1'b0, 1'b1,
                   1'b0, 1'b0, 1'b0, oe04, 1'b0, 1'b0}; // [R11]
  assign alt_val = {from_periph.timer_p1_out_1, from_periph.timer_p1_out_0,
                    from_periph.timer_p0_out_1, val32, 1'b0, val30,
                    1'b0, 1'b0, 1'b0, val04, 1'b0, 1'b0};

  // debug mode takes pin 05 whatever its mode bit says
  assign cell_alt = alt | ({{(NUM_PINS-1){1'b0}}, dbg} << PIN_05); // [R4]
  // pin 10 has no digital driver; its direction bit only picks the dac
  assign cell_dir = eff.port_direction_reg | ({{(NUM_PINS-1){1'b0}}, 1'b1} << PIN_10); // [R6]

  // ------------------------------------------------------------
  // pad cells
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      port_pin_cell u_cell (
        .clock      (clock),
        .resetn     (resetn),
        .alt_mode   (cell_alt[gi]),
        .direction  (cell_dir[gi]),
        .latch      (eff.port_latch_reg[gi]),
        .open_drain (eff.port_open_drain_reg[gi]),
        .alt_oe     (alt_oe[gi]),
        .alt_val    (alt_val[gi]),
        .pin_out_r  (pin_out[gi]),
        .pin_oe_r   (pin_oe[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // dac select and shared pin status
  // ------------------------------------------------------------
  logic dac_pin_select_nxt;
  logic conflict_nxt;

  assign dac_pin_select_nxt = (eff.port_direction_reg[PIN_10] == DIR_INPUT); // [R6]
  // flags a setup where rx and irq7 both listen; the mux itself cannot arbitrate
  assign conflict_nxt = m31_rx && uart_rx_enable_bit
                        && (irq7_rising_edge_enable || irq7_falling_edge_enable); // [R12] [R13]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dac_pin_select_r      <= 1'b0;
      shared_pin_conflict_r <= 1'b0;
    end else begin
      dac_pin_select_r      <= dac_pin_select_nxt;
      shared_pin_conflict_r <= conflict_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_rx_mode;
    m31_rx ##1 1'b1;
  endsequence

  sequence s_level_in(logic a);
    (a == 1'b1) ##1 1'b1;
  endsequence

  a_nmi_route: assert property (alt[PIN_02] ##1 alt[PIN_02] |=> // [R1]
    to_periph_r.nmi_in == $past(pin_in[PIN_02], 2) && !pin_oe[PIN_02])
    else $error("nmi not routed from pin 02");

  a_irq0_select: assert property ($stable(sel03) && m03_irq0 |=> // [R2]
    to_periph_r.ext_irq_in_0 == $past(pin_s[PIN_03]) && !to_periph_r.rtc_one_hertz)
    else $error("pin 03 irq0 selection wrong");

  a_rtc_clock: assert property (oe04 && sel04 == P04_RTC_CLK_OUT // [R3]
    && !eff.port_open_drain_reg[PIN_04]
    |=> pin_oe[PIN_04] && pin_out[PIN_04] == $past(from_periph.rtc_clk_out))
    else $error("pin 04 rtc clock not driven");

  a_debug_wins: assert property (dbg |=> // [R4]
    !to_periph_r.ext_irq_in_2 && to_periph_r.debug_reset_in == $past(pin_s[PIN_05])
    && !pin_oe[PIN_05])
    else $error("debug mode did not take pin 05");

  a_irq3_route: assert property (!alt[PIN_06] |=> !to_periph_r.ext_irq_in_3) // [R5]
    else $error("irq3 active with pin 06 in port mode");

  a_dac_select: assert property (dac_pin_select_nxt |=> // [R6]
    dac_pin_select_r && !pin_oe[PIN_10])
    else $error("pin 10 driven while dac selected");

  a_tx_route: assert property (alt[PIN_30] && fsel[PIN_30] == FUNC_0 // [R7]
    && !eff.port_open_drain_reg[PIN_30] |=>
    pin_oe[PIN_30] && pin_out[PIN_30] == $past(from_periph.uart_tx_out))
    else $error("uart tx not on pin 30");

  a_rx_shared: assert property (s_rx_mode |-> // [R8]
    to_periph_r.uart_rx_in == to_periph_r.ext_irq_in_7 && !to_periph_r.serial_data_in)
    else $error("pin 31 rx and irq7 differ");

  a_sclk_follow: assert property (alt[PIN_32] && sel32 == P32_SCLK // [R9]
    && !eff.port_open_drain_reg[PIN_32] |=>
    pin_oe[PIN_32] == $past(from_periph.serial_clk_oe))
    else $error("serial clock direction not followed");

  a_timer_out: assert property (alt[PIN_33] && oe33 // [R10]
    && !eff.port_open_drain_reg[PIN_33] |=>
    pin_oe[PIN_33] && pin_out[PIN_33] == $past(from_periph.timer_p0_out_1))
    else $error("timer p0 output 1 not on pin 33");

  a_cap_in: assert property (s_level_in(m35_in) |-> // [R10]
    to_periph_r.timer_p1_cap_in_1 == $past(pin_s[PIN_35]))
    else $error("pin 35 capture input wrong");

  a_small_ext: assert property (!eff.port_alt_enable_reg[PIN_10] // [R14] [R15] [R16]
    && (!SMALL_VARIANT || (!eff.port_func_select_ext_reg[PIN_32]
    && !eff.port_direction_reg[PIN_10])))
    else $error("absent control bit visible");

  a_gpio_drive: assert property (!alt[PIN_33] // [R17]
    && eff.port_direction_reg[PIN_33] != DIR_INPUT
    && !eff.port_open_drain_reg[PIN_33] |=>
    pin_oe[PIN_33] && pin_out[PIN_33] == $past(eff.port_latch_reg[PIN_33]))
    else $error("general purpose drive wrong");

  a_reserved_quiet: assert property (alt[PIN_04] && sel04 == P04_RSVD |=> // [R18]
    !pin_oe[PIN_04])
    else $error("reserved code drives pin 04");

endmodule
`default_nettype wire

// file: port_board_model.sv
// board pads and peripheral drivers seen from the port pin mux
// assumes pad enable high means the mux drives the pad
`timescale 1ns/10ps
`default_nettype none
module port_board_model (
  // pad side
  input  wire logic [11:0]               pin_out,
  input  wire logic [11:0]               pin_oe,
  output logic [11:0]                    pin_in,
  // board and peripheral drive
  input  wire logic [11:0]               board_val,
  input  wire port_mux_pkg::periph_out_t periph_val,
  output port_mux_pkg::periph_out_t      from_periph
);
  import port_mux_pkg::*;
  // mux drive wins; a released pad shows the board level, never the last driven value
  assign pin_in      = (pin_oe & pin_out) | (~pin_oe & board_val);
  assign from_periph = periph_val;
endmodule
`default_nettype wire

// file: port_mux_pkg.sv
// pin numbering, selection codes, presence masks and carriers for the port pin mux
// assumes one peripheral clock domain; pins are sampled synchronously
package port_mux_pkg;

  // ------------------------------------------------------------
  // pin indices
  // ------------------------------------------------------------
  localparam int NUM_PINS = 12;
  localparam int PIN_02   = 0;
  localparam int PIN_03   = 1;
  localparam int PIN_04   = 2;
  localparam int PIN_05   = 3;
  localparam int PIN_06   = 4;
  localparam int PIN_10   = 5;
  localparam int PIN_30   = 6;
  localparam int PIN_31   = 7;
  localparam int PIN_32   = 8;
  localparam int PIN_33   = 9;
  localparam int PIN_34   = 10;
  localparam int PIN_35   = 11;

  // ------------------------------------------------------------
  // selection codes {expansion, function}
  // ------------------------------------------------------------
  localparam logic [1:0] P03_IRQ0   = 2'h0;
  localparam logic [1:0] P03_ADC    = 2'h1;
  localparam logic [1:0] P03_RTC_ONE_HERTZ = 2'h3;
  localparam logic [1:0] P04_IRQ1   = 2'h0;
  localparam logic [1:0] P04_RTC_DIVIDED_CLK_OUT = 2'h1;
  localparam logic [1:0] P04_RTC_CLK_OUT  = 2'h2;
  localparam logic [1:0] P04_RSVD   = 2'h3;
  localparam logic [1:0] P32_UCLK   = 2'h0;
  localparam logic [1:0] P32_SCLK   = 2'h1;
  localparam logic [1:0] P32_CAP    = 2'h2;
  localparam logic [1:0] P32_TOUT   = 2'h3;
  localparam logic       FUNC_0     = 1'b0;
  localparam logic       FUNC_1     = 1'b1;
  localparam logic       ALT_ON     = 1'b1;
  localparam logic       DEBUG_ON   = 1'b1;
  localparam logic       DIR_INPUT  = 1'b1;
  localparam logic       RX_IDLE    = 1'b1;

  // ------------------------------------------------------------
  // which control bits exist per pin
  // ------------------------------------------------------------
  localparam logic [NUM_PINS-1:0] ALT_PRESENT       = 12'hfdf;
  localparam logic [NUM_PINS-1:0] FUNC_PRESENT      = 12'hfc6;
  localparam logic [NUM_PINS-1:0] EXT_PRESENT_FULL  = 12'h106;
  localparam logic [NUM_PINS-1:0] EXT_PRESENT_SMALL = 12'h006;
  localparam logic [NUM_PINS-1:0] DIR_PRESENT_FULL  = 12'hfff;
  localparam logic [NUM_PINS-1:0] DIR_PRESENT_SMALL = 12'hfdf;
  localparam logic [NUM_PINS-1:0] PIN_RESET         = 12'h000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0] port_latch_reg;
    logic [NUM_PINS-1:0] port_direction_reg;
    logic [NUM_PINS-1:0] port_alt_enable_reg;
    logic [NUM_PINS-1:0] port_func_select_reg;
    logic [NUM_PINS-1:0] port_func_select_ext_reg;
    logic [NUM_PINS-1:0] port_open_drain_reg;
  } pin_ctrl_t;

  typedef struct packed {
    logic nmi_in;
    logic ext_irq_in_0;
    logic ext_irq_in_1;
    logic ext_irq_in_2;
    logic ext_irq_in_3;
    logic ext_irq_in_7;
    logic adc_ext_trigger_in;
    logic rtc_one_hertz;
    logic debug_reset_in;
    logic uart_rx_in;
    logic uart_clk_in;
    logic serial_data_in;
    logic serial_clk_in;
    logic timer_p0_cap_in_0;
    logic timer_p0_cap_in_1;
    logic timer_p1_cap_in_0;
    logic timer_p1_cap_in_1;
  } periph_in_t;

  localparam periph_in_t PERIPH_IN_RESET = 17'h00080;

  typedef struct packed {
    logic rtc_divided_clk_out;
    logic rtc_clk_out;
    logic uart_tx_out;
    logic serial_data_out;
    logic serial_clk_out;
    logic serial_clk_oe;
    logic timer_p0_out_0;
    logic timer_p0_out_1;
    logic timer_p1_out_0;
    logic timer_p1_out_1;
  } periph_out_t;

endpackage

// file: port_pin_cell.sv
// one pad driver: chooses latch or peripheral, applies open drain, registers the pad
// assumes the peripheral driver is already selected by the caller
`timescale 1ns/10ps
`default_nettype none
module port_pin_cell (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pin controls
  input  wire logic alt_mode,
  input  wire logic direction,
  input  wire logic latch,
  input  wire logic open_drain,
  // selected peripheral driver
  input  wire logic alt_oe,
  input  wire logic alt_val,
  // pad side
  output logic      pin_out_r,
  output logic      pin_oe_r
);
  import port_mux_pkg::*;

  logic drive;
  logic value;
  logic pin_oe_nxt;
  logic pin_out_nxt;

  assign drive       = alt_mode ? alt_oe : (direction != DIR_INPUT); // [R11] [R17]
  assign value       = alt_mode ? alt_val : latch; // [R17]
  // open drain only pulls low; a high level lets the pad float
  assign pin_oe_nxt  = drive & ~(open_drain & value);
  assign pin_out_nxt = value & ~open_drain;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

endmodule
`default_nettype wire

// file: port_reg_presence.sv
// masks control bits that the chosen variant does not implement; absent bits read 0
// assumes the raw bits come straight from software-written control ports
`timescale 1ns/10ps
`default_nettype none
module port_reg_presence #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // raw and effective controls
  input  wire port_mux_pkg::pin_ctrl_t raw,
  output port_mux_pkg::pin_ctrl_t      eff
);
  import port_mux_pkg::*;

  logic [NUM_PINS-1:0] ext_mask;
  logic [NUM_PINS-1:0] dir_mask;

  assign ext_mask = SMALL_VARIANT ? EXT_PRESENT_SMALL : EXT_PRESENT_FULL; // [R14]
  assign dir_mask = SMALL_VARIANT ? DIR_PRESENT_SMALL : DIR_PRESENT_FULL; // [R16]

  assign eff = '{
    port_latch_reg:           raw.port_latch_reg,
    port_direction_reg:       raw.port_direction_reg & dir_mask,
    port_alt_enable_reg:      raw.port_alt_enable_reg & ALT_PRESENT, // [R15]
    port_func_select_reg:     raw.port_func_select_reg & FUNC_PRESENT, // [R15]
    port_func_select_ext_reg: raw.port_func_select_ext_reg & ext_mask,
    port_open_drain_reg:      raw.port_open_drain_reg & ALT_PRESENT // [R15]
  };

endmodule
`default_nettype wire

// file: tb_port_alternate_function_mux.sv
// self-checking bench for the port alternate-function mux
// assumes the board model resolves each pad from drive enable and board level
`timescale 1ns/10ps
`default_nettype none
module tb_port_alternate_function_mux;
  import port_mux_pkg::*;
  // uart receive idles high, every other input idles low
  localparam logic [16:0] IDLE_IN = 17'h00080;
  logic        clock;
  logic        resetn;
  pin_ctrl_t   ctrl;
  logic        dbg;
  logic        rise;
  logic        fall;
  logic        rx_en;
  periph_out_t periph_val;
  periph_out_t from_periph;
  periph_in_t  to_periph_r;
  logic        dac_sel;
  logic        conflict;
  logic [11:0] pin_in;
  logic [11:0] pin_out;
  logic [11:0] pin_oe;
  logic [11:0] pin_level_r;
  logic [11:0] board_val;
  int          n_fail;
  int          tests_run;

  port_alternate_function_mux u_port_alternate_function_mux (
    .clock(clock), .resetn(resetn), .ctrl(ctrl), .onchip_debug_mode_bit(dbg),
    .irq7_rising_edge_enable(rise), .irq7_falling_edge_enable(fall),
    .uart_rx_enable_bit(rx_en), .from_periph(from_periph), .to_periph_r(to_periph_r),
    .dac_pin_select_r(dac_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level_r(pin_level_r), .shared_pin_conflict_r(conflict));

  port_board_model u_port_board_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .board_val(board_val),
    .periph_val(periph_val), .from_periph(from_periph));

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ----------------
  // access tasks
  // ----------------
  task automatic chk_vec(input string what, input logic [16:0] exp, input logic [16:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // port bits left as output-high on purpose: alternate mode must ignore them
  task automatic sel(input int pin, input logic [1:0] code);
    ctrl = '0;
    ctrl.port_latch_reg = 12'hfff;
    ctrl.port_alt_enable_reg[pin] = 1'b1;
    ctrl.port_func_select_ext_reg[pin] = code[1];
    ctrl.port_func_select_reg[pin] = code[0];
  endtask

  task automatic in_case(input int pin, input logic [1:0] code, input logic v,
                         input logic [16:0] flip);
    sel(pin, code);
    board_val = 12'(v) << pin;
    settle(3);
    chk_vec("to_periph", IDLE_IN ^ flip, to_periph_r);
    chk_bit("pad_enable", 1'b0, pin_oe[pin]);
  endtask

  task automatic out_case(input int pin, input logic [1:0] code, input int src, input logic on);
    sel(pin, code);
    periph_val = 10'(1) << src;
    settle(2);
    chk_bit("pad_enable", on, pin_oe[pin]);
    chk_bit("pad_value", on, pin_out[pin] & pin_oe[pin]);
    periph_val = ~(10'(1) << src);
    settle(2);
    chk_bit("pad_enable", on, pin_oe[pin]);
    chk_bit("pad_value", 1'b0, pin_out[pin] & pin_oe[pin]);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------
  // scenarios
  // ----------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    resetn = 1'b0;
    ctrl = '0;
    dbg = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    rx_en = 1'b0;
    periph_val = '0;
    board_val = '0;
    settle(20);
    chk_vec("reset_enable", 17'h0, 17'(pin_oe));
    chk_vec("reset_inputs", IDLE_IN, to_periph_r);
    resetn = 1'b1;
    in_case(PIN_02, 2'h0, 1'b1, 17'h10000);
    in_case(PIN_03, P03_IRQ0, 1'b1, 17'h08000);
    in_case(PIN_03, P03_ADC, 1'b1, 17'h00400);
    in_case(PIN_03, P03_RTC_ONE_HERTZ, 1'b1, 17'h00200);
    in_case(PIN_03, 2'h2, 1'b1, 17'h0);
    in_case(PIN_04, P04_IRQ1, 1'b1, 17'h04000);
    in_case(PIN_05, 2'h0, 1'b1, 17'h02000);
    in_case(PIN_06, 2'h0, 1'b1, 17'h01000);
    in_case(PIN_31, 2'h0, 1'b1, 17'h00800);
    in_case(PIN_31, 2'h0, 1'b0, 17'h00080);
    in_case(PIN_31, 2'h1, 1'b1, 17'h00020);
    in_case(PIN_32, P32_UCLK, 1'b1, 17'h00040);
    in_case(PIN_32, P32_SCLK, 1'b1, 17'h00010);
    in_case(PIN_32, P32_CAP, 1'b1, 17'h00008);
    in_case(PIN_33, 2'h0, 1'b1, 17'h00004);
    in_case(PIN_34, 2'h0, 1'b1, 17'h00002);
    in_case(PIN_35, 2'h0, 1'b1, 17'h00001);
    dbg = 1'b1;
    in_case(PIN_05, 2'h0, 1'b1, 17'h00100);
    dbg = 1'b0;
    out_case(PIN_04, P04_RTC_DIVIDED_CLK_OUT, 9, 1'b1);
    out_case(PIN_04, P04_RTC_CLK_OUT, 8, 1'b1);
    out_case(PIN_04, P04_RSVD, 9, 1'b0);
    out_case(PIN_30, 2'h0, 7, 1'b1);
    out_case(PIN_30, 2'h1, 6, 1'b1);
    out_case(PIN_32, P32_TOUT, 3, 1'b1);
    out_case(PIN_33, 2'h1, 2, 1'b1);
    out_case(PIN_34, 2'h1, 1, 1'b1);
    out_case(PIN_35, 2'h1, 0, 1'b1);
    ctrl = '0;
    ctrl.port_latch_reg = 12'ha5a;
    ctrl.port_open_drain_reg = 12'h003;
    settle(2);
    chk_vec("gp_enable", 17'hfdd, 17'(pin_oe));
    chk_vec("gp_value", 17'ha58, 17'(pin_out & pin_oe));
    chk_bit("dac_select", 1'b0, dac_sel);
    ctrl.port_direction_reg = 12'hfff;
    ctrl.port_alt_enable_reg[PIN_10] = 1'b1;
    board_val = 12'h3c5;
    settle(2);
    chk_vec("gp_input", 17'h3c5, 17'(pin_level_r));
    chk_vec("gp_released", 17'h0, 17'(pin_oe));
    chk_bit("dac_select", 1'b1, dac_sel);
    sel(PIN_31, 2'h0);
    rx_en = 1'b1;
    rise = 1'b1;
    settle(2);
    chk_bit("conflict", 1'b1, conflict);
    rise = 1'b0;
    settle(2);
    chk_bit("conflict", 1'b0, conflict);
    rx_en = 1'b0;
    fall = 1'b1;
    settle(2);
    chk_bit("conflict", 1'b0, conflict);
    resetn = 1'b0;
    settle(1);
    chk_vec("rereset_enable", 17'h0, 17'(pin_oe));
    chk_bit("rereset_conflict", 1'b0, conflict);
    resetn = 1'b1;
    settle(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
